/* hw/pvic_top.sv */
// Prioritized vectored interrupt controller with an AHB-Lite register slave
// Notes on behaviour
// - Trap, bad opcode and nonmaskable always enabled; others maskable onto fourteen levels.
// - Compatibility service address is FF0000h plus the fetched 16-bit vector.
// - Programmable mode: each level 0-14 picks its source via map; level 2 unused.
// - Each request sets its pending bit; per-source mask gates service.
// - Acknowledge sets the in-service bit and clears the pending bit together.
// - Vector is the base register high bits plus an 8-bit jump offset.
// - Pins sampled in phase two; rising edge sets pending; driver holds edges.
// - In standby or powerdown, a held special-function pin wakes even if masked.
// - After such wake, service runs only if that pin interrupt is enabled.
// - In idle, any enabled asserted interrupt returns the device to normal.
// - Nonmaskable pin rising edge ranks below only trap and bad opcode.
// - Nonmaskable pin high through reset gives a pending request at start.
// - Trigger select register picks edge or level per external pin.
// - Overruns set capture pending bits; a mask enables each overrun interrupt.
// - Fixed in-service tracks trap and bad opcode; level in-service tracks the rest.
// - Software writes to pending registers can set bits like hardware.
// - Global enable gates maskable service; set and cleared by instructions.
// - Higher priority first; preempt only by strictly higher; top never preempted.
// - Trap and bad opcode bypass mapping and rank above all others.
// - Four map registers of four 4-bit fields; unused fields hold Fh.
// - Default priorities 17 down to 0 with the documented vector offsets.
// - Mode bit is bit 7 of fixed pending; bits 1:0 flag bad opcode and trap.
`timescale 1ns/10ps
`default_nettype none

module pvic_top
    import pvic_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    input  wire logic [15:0] periph_req_in,
    input  wire logic [3:0]  overrun_in,
    input  wire logic [3:0]  ext_request_pin_in,
    input  wire logic [3:0]  ext_pin_special_fn_in,
    input  wire logic        nmi_pin_in,
    input  wire logic        trap_instr_in,
    input  wire logic        bad_opcode_in,
    input  wire logic        enable_ints_instr_in,
    input  wire logic        disable_ints_instr_in,
    input  wire logic        return_from_int_instr_in,
    input  wire logic        ack_in,
    input  wire logic [15:0] vector_fetch_in,
    input  wire logic        vector_fetch_valid_in,
    input  wire logic [1:0]  power_mode_in,
    output logic             irq_out,
    output logic [23:0]      vector_addr_out,
    output logic [23:0]      service_addr_out,
    output logic             wake_out,
    output logic             wake_to_isr_out,
    output logic             global_enable_out
);

    // ****************************************
    // State registers
    // ****************************************
    pvic_state_s s_q;
    pvic_state_s s_d;

    // Jump offset of a mapped level or fixed source
    function automatic logic [7:0] jump_of(input logic [4:0] rank);
        logic [7:0] j;
        j = 8'h00;
        if (rank == RANK_UOP)
            j = JMP_UOP;
        else if (rank == RANK_TRAP)
            j = JMP_TRAP;
        else if (rank < 5'h08)
            j = JMP_LOW_BASE + {2'b00, rank, 1'b0};
        else
            j = JMP_HIGH_BASE + {2'b00, rank - 5'h08, 1'b0};
        return j;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic        programmable_priority_enable;
        logic [15:0] hw_set;
        logic [3:0]  ext_hit;
        logic        nmi_hit;
        logic [3:0]  src;
        logic        elig;
        logic [4:0]  best;
        logic        best_ok;
        logic [3:0]  best_src;
        logic [4:0]  svc_top;
        logic        svc_any;
        logic [4:0]  rank;
        logic        any_enabled;
        logic        return_from_int_instr_done;
        logic [31:0] rdata;
        logic [13:0] ridx;
        programmable_priority_enable         = s_q.fixed_pend[PEN_BIT];
        hw_set      = 16'h0000;
        ext_hit     = 4'h0;
        nmi_hit     = 1'b0;
        src         = 4'h0;
        elig        = 1'b0;
        best        = 5'h00;
        best_ok     = 1'b0;
        best_src    = 4'h0;
        svc_top     = 5'h00;
        svc_any     = 1'b0;
        rank        = 5'h00;
        any_enabled = 1'b0;
        return_from_int_instr_done   = 1'b0;
        rdata       = 32'h0000_0000;
        ridx        = haddr_in[15:2];
        s_d         = s_q;

        // State time phase toggles every clock
        s_d.phase = (s_q.phase == PH_ONE) ? PH_TWO : PH_ONE;

        // Register writes in the data phase
        if (s_q.wr_pend)
        begin
            case (s_q.wr_idx)
                IDX_INT_MASK_LOW:  s_d.mask[7:0]   = hwdata_in[7:0];
                IDX_INT_MASK_HIGH: s_d.mask[15:8]  = hwdata_in[7:0];
                IDX_INT_PENDING_LOW_LOW:  s_d.pend[7:0]   = hwdata_in[7:0];
                IDX_INT_PENDING_LOW_HIGH: s_d.pend[15:8]  = hwdata_in[7:0];
                IDX_OVR_MASK:      s_d.ovr_mask    = hwdata_in[7:0];
                IDX_OVR_PEND:      s_d.ovr_pend    = hwdata_in[7:0];
                IDX_INSVC_FIXED:   s_d.insvc_fixed = hwdata_in[7:0];
                IDX_FIXED_PEND:    s_d.fixed_pend  = hwdata_in[7:0] & FIXED_PEND_WMASK;
                IDX_INSVC_LEVELS:  s_d.insvc_lvl   = hwdata_in[15:0];
                IDX_TRIG_SEL:      s_d.trig        = hwdata_in[7:0];
                IDX_MAP0:          s_d.map[15:0]   = hwdata_in[15:0];
                IDX_MAP1:          s_d.map[31:16]  = hwdata_in[15:0];
                IDX_MAP2:          s_d.map[47:32]  = hwdata_in[15:0];
                IDX_MAP3:          s_d.map[63:48]  = hwdata_in[15:0];
                IDX_VECT_BASE:     s_d.base        = hwdata_in[15:0];
                default: ;
            endcase
        end

        // Pin sampling once per state time, in phase two
        if (s_q.phase == PH_TWO)
        begin
            s_d.ext_smp = ext_request_pin_in;
            s_d.nmi_smp = nmi_pin_in;
            for (int x = 0; x < 4; x++)
            begin
                ext_hit[x] = s_q.trig[x] ? ext_request_pin_in[x]
                                         : (ext_request_pin_in[x] & ~s_q.ext_smp[x]);
            end
            nmi_hit = nmi_pin_in & ~s_q.nmi_smp;
        end

        // Hardware request sources by default priority
        hw_set            = periph_req_in & PERIPH_SRC_MASK;
        hw_set[SRC_EXT0]  = ext_hit[0];
        hw_set[SRC_EXT1]  = ext_hit[1];
        hw_set[SRC_EXT2]  = ext_hit[2];
        hw_set[SRC_EXT3]  = ext_hit[3];
        hw_set[SRC_NMI]   = nmi_hit;
        hw_set[SRC_OVR01] = |(overrun_in[1:0] & s_q.ovr_mask[1:0]);
        hw_set[SRC_OVR23] = |(overrun_in[3:2] & s_q.ovr_mask[3:2]);

        // Global enable driven by the enable and disable instructions
        if (enable_ints_instr_in)
            s_d.gie = 1'b1;
        if (disable_ints_instr_in)
            s_d.gie = 1'b0;

        // Resolver candidates: mapped levels, then nonmaskable, trap, bad opcode
        for (int l = 0; l < 15; l++)
        begin
            src  = (programmable_priority_enable) ? s_q.map[l*4 +: 4] : 4'(l);
            elig = (l != LVL_RESERVED) && (src != MAP_UNUSED) && (src != 4'(SRC_NMI))
                 && s_q.pend[src] && s_q.mask[src] && s_q.gie;
            if (elig)
            begin
                best     = 5'(l);
                best_ok  = 1'b1;
                best_src = src;
            end
        end
        if (s_q.pend[SRC_NMI])
        begin
            best     = RANK_NMI;
            best_ok  = 1'b1;
            best_src = 4'(SRC_NMI);
        end
        if (s_q.fixed_pend[TRAP_BIT])
        begin
            best    = RANK_TRAP;
            best_ok = 1'b1;
        end
        if (s_q.fixed_pend[UOP_BIT])
        begin
            best    = RANK_UOP;
            best_ok = 1'b1;
        end
        any_enabled = best_ok;

        // Highest service now running
        for (int l = 0; l < 16; l++)
        begin
            if (s_q.insvc_lvl[l])
            begin
                svc_top = 5'(l);
                svc_any = 1'b1;
            end
        end
        if (s_q.insvc_fixed[TRAP_BIT])
        begin
            svc_top = RANK_TRAP;
            svc_any = 1'b1;
        end
        if (s_q.insvc_fixed[UOP_BIT])
        begin
            svc_top = RANK_UOP;
            svc_any = 1'b1;
        end

        // Decision latched once per state time
        if (s_q.phase == PH_TWO)
        begin
            s_d.irq      = best_ok && (!svc_any || best > svc_top);
            s_d.win_rank = best;
            s_d.win_src  = best_src;
        end

        // Return clears the highest active in-service bit
        if (return_from_int_instr_in)
        begin
            if (s_q.insvc_fixed[UOP_BIT])
                s_d.insvc_fixed[UOP_BIT] = 1'b0;
            else if (s_q.insvc_fixed[TRAP_BIT])
                s_d.insvc_fixed[TRAP_BIT] = 1'b0;
            else
            begin
                for (int l = 15; l >= 0; l--)
                begin
                    if (s_q.insvc_lvl[l] && !return_from_int_instr_done)
                    begin
                        s_d.insvc_lvl[l] = 1'b0;
                        return_from_int_instr_done        = 1'b1;
                    end
                end
            end
        end

        // Acknowledge: mark in service, clear pending, form vector
        if (ack_in && s_q.irq)
        begin
            rank      = s_q.win_rank;
            s_d.irq   = 1'b0;
            s_d.vec   = {s_q.base, jump_of(rank)};
            if (rank == RANK_UOP)
            begin
                s_d.insvc_fixed[UOP_BIT] = 1'b1;
                s_d.fixed_pend[UOP_BIT]  = 1'b0;
            end
            else if (rank == RANK_TRAP)
            begin
                s_d.insvc_fixed[TRAP_BIT] = 1'b1;
                s_d.fixed_pend[TRAP_BIT]  = 1'b0;
            end
            else
            begin
                s_d.insvc_lvl[rank[3:0]]  = 1'b1;
                s_d.pend[s_q.win_src]     = 1'b0;
            end
        end

        // Hardware sets last, so an event beats a same-cycle clear
        s_d.pend                 = s_d.pend | hw_set;
        s_d.ovr_pend             = s_d.ovr_pend | {4'h0, overrun_in};
        s_d.fixed_pend[TRAP_BIT] = s_d.fixed_pend[TRAP_BIT] | trap_instr_in;
        s_d.fixed_pend[UOP_BIT]  = s_d.fixed_pend[UOP_BIT] | bad_opcode_in;

        // Compatibility service address from the fetched vector
        if (vector_fetch_valid_in)
            s_d.svc = {COMPAT_PAGE, vector_fetch_in};

        // Wake-up from power-saving modes
        s_d.wake     = 1'b0;
        s_d.wake_isr = 1'b0;
        if (power_mode_in == PM_IDLE)
        begin
            s_d.wake = any_enabled;
            s_d.wake_cnt = 8'h00;
        end
        else if (power_mode_in == PM_NORMAL)
            s_d.wake_cnt = 8'h00;
        else
        begin
            for (int x = 0; x < 4; x++)
            begin
                if (ext_request_pin_in[x] && ext_pin_special_fn_in[x])
                begin
                    if (s_q.wake_cnt[x*2 +: 2] != WAKE_CYC)
                        s_d.wake_cnt[x*2 +: 2] = s_q.wake_cnt[x*2 +: 2] + 2'd1;
                end
                else
                    s_d.wake_cnt[x*2 +: 2] = 2'd0;
                if (s_d.wake_cnt[x*2 +: 2] == WAKE_CYC)
                begin
                    s_d.wake = 1'b1;
                    if (x == 0) s_d.wake_isr = s_d.wake_isr | (s_q.mask[SRC_EXT0] & s_q.gie);
                    if (x == 1) s_d.wake_isr = s_d.wake_isr | (s_q.mask[SRC_EXT1] & s_q.gie);
                    if (x == 2) s_d.wake_isr = s_d.wake_isr | (s_q.mask[SRC_EXT2] & s_q.gie);
                    if (x == 3) s_d.wake_isr = s_d.wake_isr | (s_q.mask[SRC_EXT3] & s_q.gie);
                end
            end
        end

        // AHB-Lite address phase: decode and prepare read data
        s_d.wr_pend = 1'b0;
        if (hsel_in && htrans_in[1] && hready_in)
        begin
            s_d.wr_pend = hwrite_in && (haddr_in[31:16] == 16'h0000);
            s_d.wr_idx  = ridx;
            if (!hwrite_in && haddr_in[31:16] == 16'h0000)
            begin
                case (ridx)
                    IDX_INT_MASK_LOW:  rdata = {24'h00_0000, s_q.mask[7:0]};
                    IDX_INT_MASK_HIGH: rdata = {24'h00_0000, s_q.mask[15:8]};
                    IDX_INT_PENDING_LOW_LOW:  rdata = {24'h00_0000, s_q.pend[7:0]};
                    IDX_INT_PENDING_LOW_HIGH: rdata = {24'h00_0000, s_q.pend[15:8]};
                    IDX_OVR_MASK:      rdata = {24'h00_0000, s_q.ovr_mask};
                    IDX_OVR_PEND:      rdata = {24'h00_0000, s_q.ovr_pend};
                    IDX_INSVC_FIXED:   rdata = {24'h00_0000, s_q.insvc_fixed};
                    IDX_FIXED_PEND:    rdata = {24'h00_0000, s_q.fixed_pend};
                    IDX_INSVC_LEVELS:  rdata = {16'h0000, s_q.insvc_lvl};
                    IDX_TRIG_SEL:      rdata = {24'h00_0000, s_q.trig};
                    IDX_MAP0:          rdata = {16'h0000, s_q.map[15:0]};
                    IDX_MAP1:          rdata = {16'h0000, s_q.map[31:16]};
                    IDX_MAP2:          rdata = {16'h0000, s_q.map[47:32]};
                    IDX_MAP3:          rdata = {16'h0000, s_q.map[63:48]};
                    IDX_VECT_BASE:     rdata = {16'h0000, s_q.base};
                    IDX_PSW:           rdata = {31'h0000_0000, s_q.gie};
                    default:           rdata = 32'h0000_0000;
                endcase
            end
            s_d.hrdata = rdata;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            s_q       <= '0;
            s_q.phase <= PH_ONE;
            s_q.map   <= {4{RST_MAP}};
            s_q.base  <= RST_VECT_BASE;
        end
        else
            s_q <= s_d;
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Zero-wait slave, always OKAY
    assign hreadyout_out     = 1'b1;
    assign hresp_out         = 1'b0;
    assign hrdata_out        = s_q.hrdata;
    assign irq_out           = s_q.irq;
    assign vector_addr_out   = s_q.vec;
    assign service_addr_out  = s_q.svc;
    assign wake_out          = s_q.wake;
    assign wake_to_isr_out   = s_q.wake_isr;
    assign global_enable_out = s_q.gie;

endmodule // pvic_top

`default_nettype wire

/* hw/pvic_pkg.sv */
// Constants, register indices and state layout for the vectored interrupt controller
package pvic_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned WAKE_MIN_NS   = 50;
    // Least time, rounded up to whole cycles
    localparam int unsigned WAKE_CYC_I    = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  WAKE_CYC      = 2'(WAKE_CYC_I);

    // ****************************************
    // Register indices (byte address is four times the index)
    // ****************************************
    localparam logic [13:0] IDX_INT_MASK_LOW   = 14'h0008;
    localparam logic [13:0] IDX_INT_PENDING_LOW_LOW   = 14'h0009;
    localparam logic [13:0] IDX_INT_PENDING_LOW_HIGH  = 14'h0012;
    localparam logic [13:0] IDX_INT_MASK_HIGH  = 14'h0013;
    localparam logic [13:0] IDX_OVR_MASK       = 14'h1f9c;
    localparam logic [13:0] IDX_OVR_PEND       = 14'h1f9e;
    localparam logic [13:0] IDX_INSVC_FIXED    = 14'h1fc8;
    localparam logic [13:0] IDX_FIXED_PEND     = 14'h1fc9;
    localparam logic [13:0] IDX_INSVC_LEVELS   = 14'h1fca;
    localparam logic [13:0] IDX_TRIG_SEL       = 14'h1fcc;
    localparam logic [13:0] IDX_MAP0           = 14'h1fe8;
    localparam logic [13:0] IDX_MAP1           = 14'h1fea;
    localparam logic [13:0] IDX_MAP2           = 14'h1fec;
    localparam logic [13:0] IDX_MAP3           = 14'h1fee;
    localparam logic [13:0] IDX_VECT_BASE      = 14'h1ff0;
    localparam logic [13:0] IDX_PSW            = 14'h1ff4;

    // ****************************************
    // Reset values and field positions
    // ****************************************
    localparam logic [15:0] RST_MAP            = 16'hffff;
    localparam logic [15:0] RST_VECT_BASE      = 16'hff20;
    localparam logic [7:0]  FIXED_PEND_WMASK   = 8'h83;
    localparam int unsigned PEN_BIT            = 7;
    localparam int unsigned TRAP_BIT           = 0;
    localparam int unsigned UOP_BIT            = 1;
    localparam logic [3:0]  MAP_UNUSED         = 4'hf;
    localparam logic [7:0]  COMPAT_PAGE        = 8'hff;

    // ****************************************
    // Source positions by default priority
    // ****************************************
    localparam int unsigned SRC_EXT0           = 3;
    localparam int unsigned SRC_EXT1           = 4;
    localparam int unsigned SRC_OVR01          = 11;
    localparam int unsigned SRC_OVR23          = 12;
    localparam int unsigned SRC_EXT2           = 13;
    localparam int unsigned SRC_EXT3           = 14;
    localparam int unsigned SRC_NMI            = 15;
    localparam int unsigned LVL_RESERVED       = 2;
    localparam logic [15:0] PERIPH_SRC_MASK    = 16'h07e3;

    // Ranks above the mapped levels, and jump offsets
    localparam logic [4:0]  RANK_NMI           = 5'h0f;
    localparam logic [4:0]  RANK_TRAP          = 5'h10;
    localparam logic [4:0]  RANK_UOP           = 5'h11;
    localparam logic [7:0]  JMP_TRAP           = 8'h10;
    localparam logic [7:0]  JMP_UOP            = 8'h12;
    localparam logic [7:0]  JMP_LOW_BASE       = 8'h00;
    localparam logic [7:0]  JMP_HIGH_BASE      = 8'h30;

    // Power modes
    localparam logic [1:0]  PM_NORMAL          = 2'h0;
    localparam logic [1:0]  PM_IDLE            = 2'h1;

    // State time phases
    typedef enum logic [1:0] {
        PH_ONE = 2'b01,
        PH_TWO = 2'b10
    } pvic_phase_e;

    // Whole state of the controller
    typedef struct packed {
        pvic_phase_e phase;
        logic [15:0] mask;
        logic [15:0] pend;
        logic [7:0]  ovr_mask;
        logic [7:0]  ovr_pend;
        logic [7:0]  fixed_pend;
        logic [7:0]  insvc_fixed;
        logic [15:0] insvc_lvl;
        logic [7:0]  trig;
        logic [63:0] map;
        logic [15:0] base;
        logic        gie;
        logic [3:0]  ext_smp;
        logic        nmi_smp;
        logic        irq;
        logic [4:0]  win_rank;
        logic [3:0]  win_src;
        logic [23:0] vec;
        logic [23:0] svc;
        logic        wake;
        logic        wake_isr;
        logic [7:0]  wake_cnt;
        logic [31:0] hrdata;
        logic        wr_pend;
        logic [13:0] wr_idx;
    } pvic_state_s;

endpackage

/* sim/pvic_monitor.sv */
// Port checker for the interrupt controller, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module pvic_monitor (
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic        hresp_out,
    input wire logic        ack_in,
    input wire logic        irq_out,
    input wire logic [23:0] vector_addr_out,
    input wire logic        enable_ints_instr_in,
    input wire logic        disable_ints_instr_in,
    input wire logic        global_enable_out,
    input wire logic [15:0] vector_fetch_in,
    input wire logic        vector_fetch_valid_in,
    input wire logic [23:0] service_addr_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // An acknowledge that the controller takes
    sequence s_take; ack_in && irq_out; endsequence
    AST_OKAY: assert property (hresp_out == 1'b0) else $error("bus response not okay");
    AST_ACK_DROP: assert property (s_take |=> !irq_out) else $error("request stands after ack");
    AST_VEC_EVEN: assert property (s_take |=> !vector_addr_out[0]) else $error("odd jump offset");
    AST_VEC_HOLD: assert property (!ack_in |=> $stable(vector_addr_out)) else $error("vector moved");
    AST_GIE_ON: assert property (enable_ints_instr_in && !disable_ints_instr_in |=> global_enable_out)
        else $error("enable lost");
    AST_GIE_OFF: assert property (disable_ints_instr_in |=> !global_enable_out) else $error("disable lost");
    AST_GIE_KEEP: assert property (!enable_ints_instr_in && !disable_ints_instr_in |=> $stable(global_enable_out))
        else $error("enable changed");
    AST_IRQ_HOLD: assert property ($rose(irq_out) && !ack_in |=> irq_out) else $error("request glitch");
    AST_SVC: assert property (vector_fetch_valid_in |=> service_addr_out == {8'hff, $past(vector_fetch_in)})
        else $error("service address wrong");
endmodule // pvic_monitor
bind pvic_top pvic_monitor u_mon (.sys_clk_in, .rst_in, .hresp_out, .ack_in, .irq_out, .vector_addr_out,
    .enable_ints_instr_in, .disable_ints_instr_in, .global_enable_out, .vector_fetch_in,
    .vector_fetch_valid_in, .service_addr_out);
`default_nettype wire

/* sim/pvic_cpu_model.sv */
// CPU core model that acknowledges a raised request after a delay
`timescale 1ns/10ps
`default_nettype none
module pvic_cpu_model #(parameter int unsigned DLY = 1) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic irq_in,
    output logic      ack_out
);
    logic [3:0] cnt_q;
    // One-cycle acknowledge once the request has stood DLY cycles
    always_ff @(posedge clk_in)
    begin
        cnt_q   <= (rst_in || !irq_in || ack_out) ? 4'h0 : cnt_q + 4'h1;
        ack_out <= !rst_in && irq_in && !ack_out && cnt_q >= 4'(DLY);
    end
endmodule // pvic_cpu_model
`default_nettype wire

/* sim/prioritized_vectored_interrupt_ctl_test.sv */
// Register and acknowledge tests of the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module prioritized_vectored_interrupt_ctl_test;
    import pvic_pkg::*;
    logic        sys_clk_in, rst_in, hsel_in, hwrite_in, nmi_pin_in, ack_in, irq_out, hreadyout_out, hresp_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out;
    logic [1:0]  htrans_in;
    logic [15:0] periph_req_in, vector_fetch_in;
    logic [23:0] vector_addr_out, service_addr_out;
    logic [5:0]  pl;
    logic [3:0]  ext_pin;
    int          n_mismatch, cmp_count, cyc;
    pvic_top DUT (.sys_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in,
        .hready_in(hreadyout_out), .hreadyout_out, .hresp_out, .hrdata_out, .periph_req_in, .overrun_in(4'h0),
        .ext_request_pin_in(ext_pin), .ext_pin_special_fn_in(4'h0), .nmi_pin_in, .trap_instr_in(pl[0]),
        .bad_opcode_in(pl[1]), .enable_ints_instr_in(pl[2]), .disable_ints_instr_in(pl[3]),
        .return_from_int_instr_in(pl[4]), .ack_in, .vector_fetch_in, .vector_fetch_valid_in(pl[5]),
        .power_mode_in(2'h0), .irq_out, .vector_addr_out, .service_addr_out, .wake_out(), .wake_to_isr_out(),
        .global_enable_out());
    pvic_cpu_model #(.DLY(2)) u_cpu (.clk_in(sys_clk_in), .rst_in, .irq_in(irq_out), .ack_out(ack_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One single-word bus transfer: address phase, then data phase
    task automatic bus(input logic [13:0] idx, input logic wr, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_in);
        hsel_in   <= 1'b1;
        htrans_in <= 2'b10;
        hwrite_in <= wr;
        haddr_in  <= {16'h0000, idx, 2'b00};
        do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'b00;
        hsel_in   <= 1'b0;
        hwdata_in <= d;
        do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
        q = hrdata_out;
    endtask
    task automatic wr(input logic [13:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(idx, 1'b1, d, q);
    endtask
    task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(idx, 1'b0, 32'h0000_0000, q);
        chk(q, exp);
    endtask
    task automatic pulse(input int b);
        @(posedge sys_clk_in);
        pl[b] <= 1'b1;
        @(posedge sys_clk_in);
        pl <= 6'h00;
    endtask
    // Wait for a taken acknowledge, then compare the vector it produced
    task automatic take(input logic [23:0] exp);
        int k;
        k = 0;
        @(posedge sys_clk_in);
        while (!(ack_in === 1'b1 && irq_out === 1'b1) && k < 200) begin @(posedge sys_clk_in); k++; end
        if (k >= 200) n_mismatch++;
        @(posedge sys_clk_in);
        chk({8'h00, vector_addr_out}, {8'h00, exp});
    endtask
    initial begin sys_clk_in = 1'b0; forever #20 sys_clk_in = ~sys_clk_in; end
    // Cut a hang short
    always @(posedge sys_clk_in) begin cyc++; if (cyc == 20000) begin n_mismatch++; test_done(); end end
    initial
    begin
        {hsel_in, hwrite_in, nmi_pin_in, htrans_in, pl, ext_pin, haddr_in, hwdata_in, periph_req_in, vector_fetch_in} = '0;
        rst_in = 1'b1;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rd(IDX_VECT_BASE, 32'h0000_ff20);
        rd(IDX_MAP0, 32'h0000_ffff);
        rd(IDX_FIXED_PEND, 32'h0000_0000);
        rd(14'h0100, 32'h0000_0000);
        nmi_pin_in <= 1'b1;
        take(24'hff_203e);
        rd(IDX_INSVC_LEVELS, 32'h0000_8000);
        pulse(4);
        rd(IDX_INSVC_LEVELS, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin pulse(i); take(24'hff_2010 + 24'(2 * i)); pulse(4); end
        rd(IDX_INSVC_FIXED, 32'h0000_0000);
        wr(IDX_INT_MASK_LOW, 32'h0000_0001);
        wr(IDX_INT_PENDING_LOW_LOW, 32'h0000_0001);
        repeat (6) @(posedge sys_clk_in);
        chk({31'h0, irq_out}, 32'h0000_0000);
        pulse(2);
        take(24'hff_2000);
        @(posedge sys_clk_in);
        periph_req_in <= 16'h0002;
        @(posedge sys_clk_in);
        periph_req_in <= 16'h0000;
        rd(IDX_INT_PENDING_LOW_LOW, 32'h0000_0002);
        wr(IDX_INT_MASK_LOW, 32'h0000_0003);
        take(24'hff_2002);
        pulse(4);
        pulse(4);
        wr(IDX_INT_MASK_LOW, 32'h0000_000b);
        ext_pin <= 4'h1;
        take(24'hff_2006);
        pulse(4);
        wr(IDX_FIXED_PEND, 32'h0000_0080);
        wr(IDX_MAP1, 32'h0000_1fff);
        wr(IDX_INT_PENDING_LOW_LOW, 32'h0000_0002);
        take(24'hff_200e);
        vector_fetch_in <= 16'h2080;
        pulse(5);
        @(posedge sys_clk_in);
        chk({8'h00, service_addr_out}, 32'h00ff_2080);
        test_done();
    end
endmodule // prioritized_vectored_interrupt_ctl_test
`default_nettype wire
